// file: hw/msrb_top.sv
// module reset supervisor, watchdog, power-fail follower and boot mode sequencer
// assumes all pin inputs are asynchronous; one 100 MHz clock, synchronous active-low reset
//
// What this block does
// [RULE1] any supply rail flagged low forces module reset for as long as it lasts
// [RULE2] 1.8 s watchdog restarted by the trigger input resets the module on expiry
// [RULE3] power-fail output goes low while the power-fail input is below threshold
// [RULE4] manual reset input held low starts a module reset
// [RULE5] after any reset the module reset output stays low for 53 ms
// [RULE6] after reset decode boot select: 00 rom, 10 nor flash, 11 serial download
// [RULE7] serial mode polls uart and usb 32 s, then powers down if idle
// [RULE8] in a serial session the boot watchdog is serviced; 32 s stall powers down
// [RULE9] module reset combines all sources; stretch counts from last source clearing
`timescale 1ns/1ps
module msrb_top
    import msrb_pkg::*;
#(
    parameter logic [TMR_W-1:0] BOOT_WATCHDOG_CNT = TMR_W'(BOOT_WATCHDOG_CYCLES),
    parameter logic [TMR_W-1:0] STRETCH_CNT = TMR_W'(STRETCH_CYCLES),
    parameter logic [TMR_W-1:0] BOOT_WD_CNT = TMR_W'(BOOT_WD_CYCLES)
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // supervisor pins
    input wire logic [msrb_pkg::NUM_RAILS-1:0] supply_low_i,
    input wire logic manual_reset_in_n_i,
    input wire logic watchdog_trigger_in_i,
    input wire logic power_fail_in_n_i,
    // boot straps and serial port activity
    input wire logic [1:0] boot_select_i,
    input wire logic uart_active_i,
    input wire logic usb_active_i,
    input wire logic boot_service_i,
    // outputs
    output logic module_reset_n_o,
    output logic power_fail_out_n_o,
    output msrb_pkg::msrb_boot_t boot_mode_o,
    output logic power_down_o
);
    import msrb_pkg::*;

    msrb_pins_t pins_raw;
    msrb_pins_t sync1_q;
    msrb_pins_t sync2_q;
    logic wdi_prev_q;
    logic service_prev_q;
    logic module_reset_n_q;
    logic power_fail_out_n_q;
    msrb_boot_t boot_mode_q;
    logic power_down_q;
    logic [1:0] strap_q;
    msrb_state_t state_q;
    msrb_state_t state_d;

    assign pins_raw = '{
        supply_low: supply_low_i,
        manual_reset_in_n: manual_reset_in_n_i,
        watchdog_trigger_in: watchdog_trigger_in_i,
        power_fail_in_n: power_fail_in_n_i,
        boot_select: boot_select_i,
        uart_active: uart_active_i,
        usb_active: usb_active_i,
        boot_service: boot_service_i
    };

    // two-flop synchroniser; only sync2_q is read by logic
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sync1_q <= PINS_RST;
            sync2_q <= PINS_RST;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // edge history for the trigger and the boot service strobe
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wdi_prev_q <= 1'b0;
            service_prev_q <= 1'b0;
        end else begin
            wdi_prev_q <= sync2_q.watchdog_trigger_in;
            service_prev_q <= sync2_q.boot_service;
        end
    end

    // reset sources
    wire rail_low = |sync2_q.supply_low; // RULE1
    wire manual_rst = !sync2_q.manual_reset_in_n; // RULE4
    wire wdi_edge = sync2_q.watchdog_trigger_in != wdi_prev_q; // either edge counts as a kick
    wire boot_watchdog_expired;
    wire stretch_expired;
    wire any_src = rail_low || manual_rst || boot_watchdog_expired; // RULE9

    // supervisor watchdog; held reloaded while the module is in reset so it cannot re-fire
    msrb_timer #(.W(TMR_W)) u_boot_watchdog (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .load_i(wdi_edge || boot_watchdog_expired || !module_reset_n_q), // RULE2
        .count_en_i(module_reset_n_q),
        .value_i(BOOT_WATCHDOG_CNT),
        .expired_o(boot_watchdog_expired)
    );

    // stretch timer: reloaded while any source is active, runs once all have cleared
    msrb_timer #(.W(TMR_W)) u_stretch (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .load_i(any_src), // RULE9
        .count_en_i(!module_reset_n_q),
        .value_i(STRETCH_CNT),
        .expired_o(stretch_expired)
    );

    // module reset output; also low after system reset until a full stretch has run
    wire reset_n_d = any_src ? 1'b0 : (module_reset_n_q || stretch_expired); // RULE5

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            module_reset_n_q <= 1'b0;
            power_fail_out_n_q <= 1'b1;
        end else begin
            module_reset_n_q <= reset_n_d; // RULE1
            power_fail_out_n_q <= sync2_q.power_fail_in_n; // RULE3
        end
    end

    // boot sequencer
    wire serial_act = sync2_q.uart_active || sync2_q.usb_active;
    wire service_pulse = sync2_q.boot_service && !service_prev_q;
    wire boot_wd_expired;
    wire in_serial = state_q == MSRB_ST_POLL || state_q == MSRB_ST_SESSION;
    wire enter_serial = state_q == MSRB_ST_DECODE && strap_q == BOOT_SEL_SERIAL;
    wire boot_wd_load = enter_serial || (state_q == MSRB_ST_POLL && serial_act) ||
                        (state_q == MSRB_ST_SESSION && service_pulse); // RULE8

    // one timer serves the polling window and the session watchdog
    msrb_timer #(.W(TMR_W)) u_boot_wd (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .load_i(boot_wd_load),
        .count_en_i(in_serial),
        .value_i(BOOT_WD_CNT),
        .expired_o(boot_wd_expired)
    );

    // next state; a new module reset returns to hold from every state except off
    always_comb begin
        state_d = state_q;
        case (state_q)
            MSRB_ST_HOLD: begin
                if (module_reset_n_q) begin
                    state_d = MSRB_ST_DECODE;
                end
            end
            MSRB_ST_DECODE: begin
                case (strap_q) // RULE6
                    BOOT_SEL_ROM: state_d = MSRB_ST_ROM;
                    BOOT_SEL_SERIAL: state_d = MSRB_ST_POLL;
                    default: state_d = MSRB_ST_NOR;
                endcase
            end
            MSRB_ST_POLL: begin
                if (boot_wd_expired) begin
                    state_d = MSRB_ST_OFF; // RULE7
                end else if (serial_act) begin
                    state_d = MSRB_ST_SESSION;
                end
            end
            MSRB_ST_SESSION: begin
                if (boot_wd_expired) begin
                    state_d = MSRB_ST_OFF; // RULE8
                end
            end
            MSRB_ST_OFF: state_d = MSRB_ST_OFF; // only system reset leaves power down
            MSRB_ST_ROM: state_d = MSRB_ST_ROM;
            MSRB_ST_NOR: state_d = MSRB_ST_NOR;
            default: state_d = MSRB_ST_HOLD;
        endcase
        if (!module_reset_n_q && state_q != MSRB_ST_OFF) begin
            state_d = MSRB_ST_HOLD;
        end
    end

    // mode decode for the output register
    wire msrb_boot_t mode_d = (state_d == MSRB_ST_ROM) ? MSRB_BOOT_ROM :
                              (state_d == MSRB_ST_NOR) ? MSRB_BOOT_NOR :
                              (state_d == MSRB_ST_POLL || state_d == MSRB_ST_SESSION ||
                               state_d == MSRB_ST_OFF) ? MSRB_BOOT_SERIAL : MSRB_BOOT_NONE;

    // strap is caught by a clocked process on the cycle the module reset releases
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_q <= MSRB_ST_HOLD;
            strap_q <= BOOT_SEL_NOR;
            boot_mode_q <= MSRB_BOOT_NONE;
            power_down_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == MSRB_ST_HOLD) begin
                strap_q <= sync2_q.boot_select; // RULE6
            end
            boot_mode_q <= mode_d;
            power_down_q <= state_d == MSRB_ST_OFF; // RULE7
        end
    end

    assign module_reset_n_o = module_reset_n_q;
    assign power_fail_out_n_o = power_fail_out_n_q;
    assign boot_mode_o = boot_mode_q;
    assign power_down_o = power_down_q;

    // checks
    sequence s_src_seen;
        any_src;
    endsequence
    sequence s_rst_low;
        !module_reset_n_o;
    endsequence

    a_rail_low_reset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE1
        rail_low |=> s_rst_low) else $error("rail low without module reset");
    a_boot_watchdog_expiry_reset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE2
        boot_watchdog_expired |=> s_rst_low) else $error("watchdog expiry did not reset");
    a_pfo_follows_pfi: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE3
        $past(sync2_q.power_fail_in_n) != power_fail_out_n_o |-> !$past(resetn_i))
        else $error("power-fail output does not follow input");
    a_manual_reset_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE4
        manual_rst[*2] |=> s_rst_low) else $error("manual reset ignored");
    a_stretch_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE5
        $rose(module_reset_n_o) |-> $past(stretch_expired) && !$past(any_src))
        else $error("reset released before stretch elapsed");
    a_stretch_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE9
        s_src_seen ##1 !any_src |-> s_rst_low [*8]) else $error("stretch not measured from last source");
    a_boot_decode_map: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE6
        state_q == MSRB_ST_DECODE && module_reset_n_q |=>
        boot_mode_o == (strap_q == BOOT_SEL_ROM ? MSRB_BOOT_ROM :
                        strap_q == BOOT_SEL_SERIAL ? MSRB_BOOT_SERIAL : MSRB_BOOT_NOR))
        else $error("boot select decoded wrongly");
    a_poll_timeout_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE7
        state_q == MSRB_ST_POLL && boot_wd_expired |=> power_down_o) else $error("idle poll did not power down");
    a_session_stall_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE8
        state_q == MSRB_ST_SESSION && boot_wd_expired |=> power_down_o ##1 power_down_o)
        else $error("stalled session did not power down");
endmodule

// file: hw/msrb_pkg.sv
// package for the module reset supervisor and boot selector
// assumes a single 100 MHz system clock; every time below is turned into cycles here
package msrb_pkg;

    // clock rate and times as printed
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned BOOT_WATCHDOG_TIME_MS = 1800;
    localparam longint unsigned STRETCH_TIME_MS = 53;
    localparam longint unsigned BOOT_WD_TIME_S = 32;

    // cycle counts derived from the times (all exact, so no rounding issue)
    localparam longint unsigned BOOT_WATCHDOG_CYCLES = (BOOT_WATCHDOG_TIME_MS * CLK_HZ) / 64'd1000;
    localparam longint unsigned STRETCH_CYCLES = (STRETCH_TIME_MS * CLK_HZ) / 64'd1000;
    localparam longint unsigned BOOT_WD_CYCLES = BOOT_WD_TIME_S * CLK_HZ;

    // monitored supply rails and timer width
    localparam int unsigned NUM_RAILS = 6;
    localparam int unsigned TMR_W = 32;

    // boot selection encodings
    localparam logic [1:0] BOOT_SEL_ROM = 2'h0;
    localparam logic [1:0] BOOT_SEL_NOR = 2'h2;
    localparam logic [1:0] BOOT_SEL_SERIAL = 2'h3;

    // decoded boot mode
    typedef enum logic [1:0] {
        MSRB_BOOT_NONE = 2'h0,
        MSRB_BOOT_ROM = 2'h1,
        MSRB_BOOT_NOR = 2'h2,
        MSRB_BOOT_SERIAL = 2'h3
    } msrb_boot_t;

    // boot sequencer states, gray along hold-decode-poll-session-off
    typedef enum logic [2:0] {
        MSRB_ST_HOLD = 3'h0,
        MSRB_ST_DECODE = 3'h1,
        MSRB_ST_POLL = 3'h3,
        MSRB_ST_SESSION = 3'h2,
        MSRB_ST_OFF = 3'h6,
        MSRB_ST_ROM = 3'h4,
        MSRB_ST_NOR = 3'h5
    } msrb_state_t;

    // all asynchronous pin inputs travel together through the synchroniser
    typedef struct packed {
        logic [NUM_RAILS-1:0] supply_low;
        logic manual_reset_in_n;
        logic watchdog_trigger_in;
        logic power_fail_in_n;
        logic [1:0] boot_select;
        logic uart_active;
        logic usb_active;
        logic boot_service;
    } msrb_pins_t;

    // synchroniser contents after reset: no rail low, buttons released
    localparam msrb_pins_t PINS_RST = '{
        supply_low: '0,
        manual_reset_in_n: 1'b1,
        watchdog_trigger_in: 1'b0,
        power_fail_in_n: 1'b1,
        boot_select: BOOT_SEL_NOR,
        uart_active: 1'b0,
        usb_active: 1'b0,
        boot_service: 1'b0
    };

endpackage

// file: hw/msrb_timer.sv
// down-counting timer with load, count enable and registered expiry level
// assumes load and enable come from logic on the same clock
`timescale 1ns/1ps
module msrb_timer #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // control
    input wire logic load_i,
    input wire logic count_en_i,
    input wire logic [W-1:0] value_i,
    // status
    output logic expired_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic expired_q;

    // load wins over counting; the counter parks at zero
    assign cnt_d = load_i ? value_i :
                   (count_en_i && cnt_q != '0) ? cnt_q - W'(1) : cnt_q;

    // expiry is high while the count rests at zero, counting is enabled and no reload is pending
    // reset loads the full count: a counter parked at zero would report expiry right after release
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_q <= value_i;
            expired_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            expired_q <= !load_i && count_en_i && cnt_d == '0;
        end
    end

    assign expired_o = expired_q;
endmodule

// file: dv/msrb_carrier.sv
// carrier board model: watchdog kicker, manual reset button and power-fail comparator
// assumes the bench changes its requests just after a rising edge of clk_sys_i
`timescale 1ns/1ps
module msrb_carrier #(
    parameter int unsigned KICK_GAP = 20
) (
    // clock
    input wire logic clk_sys_i,
    // bench requests
    input wire logic kick_en_i,
    input wire logic mr_req_i,
    input wire logic pf_req_i,
    // carrier pins
    output logic watchdog_trigger_in_o = 1'h0,
    output logic manual_reset_in_n_o = 1'h1,
    output logic power_fail_in_n_o = 1'h1
);
    int unsigned gap_q = 0;

    // kicks land well inside the watchdog period; a hang is shown by stopping them
    always @(posedge clk_sys_i) begin
        gap_q <= (gap_q >= KICK_GAP - 1) ? 0 : gap_q + 1;
        if (kick_en_i && gap_q >= KICK_GAP - 1) begin
            watchdog_trigger_in_o <= ~watchdog_trigger_in_o;
        end
        manual_reset_in_n_o <= ~mr_req_i; // button shorts the pin to ground
        power_fail_in_n_o <= ~pf_req_i; // power-good output pulls the pin low
    end
endmodule

// file: dv/msrb_top_tb.sv
// self-checking bench for the reset supervisor and boot selector
// assumes the carrier model drives the trigger, manual reset and power-fail pins, the bench the rails; timers are shortened by parameters
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module msrb_top_tb;
    import msrb_pkg::*;
    localparam int WD = 50;
    localparam int ST = 20;
    localparam int BW = 40;
    localparam int KG = 20;
    logic clk_sys_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [NUM_RAILS-1:0] supply_low_i = '0;
    logic kick_en = 1'h1;
    logic mr_req = 1'h0;
    logic pf_req = 1'h0;
    logic [1:0] boot_select_i = BOOT_SEL_NOR;
    logic uart_active_i = 1'h0;
    logic usb_active_i = 1'h0;
    logic boot_service_i = 1'h0;
    logic trig;
    logic mr_n;
    logic pf_n;
    logic module_reset_n_o;
    logic power_fail_out_n_o;
    logic power_down_o;
    msrb_boot_t boot_mode_o;
    int n_mismatch = 0;
    int compares = 0;
    int n;

    // 100 MHz system clock
    always #5 clk_sys_i = ~clk_sys_i;

    msrb_carrier #(.KICK_GAP(KG)) u_carrier (.clk_sys_i(clk_sys_i), .kick_en_i(kick_en), .mr_req_i(mr_req),
        .pf_req_i(pf_req), .watchdog_trigger_in_o(trig), .manual_reset_in_n_o(mr_n), .power_fail_in_n_o(pf_n));

    msrb_top #(.BOOT_WATCHDOG_CNT(TMR_W'(WD)), .STRETCH_CNT(TMR_W'(ST)), .BOOT_WD_CNT(TMR_W'(BW))) DUT (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .supply_low_i(supply_low_i), .manual_reset_in_n_i(mr_n),
        .watchdog_trigger_in_i(trig), .power_fail_in_n_i(pf_n), .boot_select_i(boot_select_i),
        .uart_active_i(uart_active_i), .usb_active_i(usb_active_i), .boot_service_i(boot_service_i),
        .module_reset_n_o(module_reset_n_o), .power_fail_out_n_o(power_fail_out_n_o),
        .boot_mode_o(boot_mode_o), .power_down_o(power_down_o));

    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reads right after the edge see the settled values of the cycle before
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk_sys_i);
    endtask

    // bounded wait; which: 0 module reset level, 1 power-down high, 2 power-fail out level
    task automatic wait_on(input int which, input logic lvl, input int bound, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'h0;
        while (!hit) begin
            tick();
            cnt++;
            case (which)
                0: hit = (module_reset_n_o === lvl);
                1: hit = (power_down_o === 1'h1);
                default: hit = (power_fail_out_n_o === lvl);
            endcase
            if (!hit && cnt >= bound) begin
                n_mismatch++;
                $display("mismatch wait %0d expected %0h seen timeout", which, lvl);
                close_out();
            end
        end
    endtask

    // new strap, then a button press so that it is sampled again
    task automatic restrap(input logic [1:0] s);
        boot_select_i <= s;
        mr_req <= 1'h1;
        tick(6);
        mr_req <= 1'h0;
        wait_on(0, 1'h1, ST + 20, n);
        tick(3);
    endtask

    task automatic sys_reset();
        tick();
        resetn_i <= 1'h0;
        tick(5);
        `CHK("mode in reset", MSRB_BOOT_NONE, boot_mode_o)
        resetn_i <= 1'h1;
        wait_on(0, 1'h1, ST + 20, n);
        `CHK("stretch after release", 1'h1, n >= ST && n <= ST + 8)
        tick(3);
    endtask

    task automatic t_manual();
        mr_req <= 1'h1;
        wait_on(0, 1'h0, 6, n);
        supply_low_i <= 6'h01;
        tick(10);
        mr_req <= 1'h0;
        tick(ST + 10);
        `CHK("reset held by rail", 1'h0, module_reset_n_o)
        supply_low_i <= 6'h00;
        wait_on(0, 1'h1, ST + 20, n);
        `CHK("stretch after last source", 1'h1, n >= ST && n <= ST + 8)
        $display("test manual done");
    endtask

    task automatic t_rails();
        for (int i = 0; i < NUM_RAILS; i++) begin
            supply_low_i <= 6'h01 << i;
            wait_on(0, 1'h0, 6, n);
            tick(ST + 10);
            `CHK("reset while rail low", 1'h0, module_reset_n_o)
            supply_low_i <= 6'h00;
            wait_on(0, 1'h1, ST + 20, n);
        end
        $display("test rails done");
    endtask

    task automatic t_pfail();
        pf_req <= 1'h1;
        wait_on(2, 1'h0, 6, n);
        tick(5);
        `CHK("power fail out held", 1'h0, power_fail_out_n_o)
        pf_req <= 1'h0;
        wait_on(2, 1'h1, 6, n);
        $display("test power fail done");
    endtask

    task automatic t_boot_watchdog();
        tick(WD * 3);
        `CHK("kicked watchdog quiet", 1'h1, module_reset_n_o)
        kick_en <= 1'h0;
        wait_on(0, 1'h0, WD + 10, n);
        `CHK("watchdog expiry time", 1'h1, n >= WD - KG - 1 && n <= WD + 8)
        kick_en <= 1'h1;
        wait_on(0, 1'h1, ST + 20, n);
        $display("test watchdog done");
    endtask

    task automatic t_modes();
        logic [1:0] sel [3] = '{BOOT_SEL_ROM, BOOT_SEL_NOR, 2'h1};
        msrb_boot_t exp [3] = '{MSRB_BOOT_ROM, MSRB_BOOT_NOR, MSRB_BOOT_NOR};
        for (int i = 0; i < 3; i++) begin
            restrap(sel[i]);
            `CHK("boot mode", exp[i], boot_mode_o)
        end
        boot_select_i <= BOOT_SEL_ROM;
        tick(10);
        `CHK("strap ignored after decode", MSRB_BOOT_NOR, boot_mode_o)
        $display("test modes done");
    endtask

    task automatic t_idle();
        restrap(BOOT_SEL_SERIAL);
        `CHK("serial mode", MSRB_BOOT_SERIAL, boot_mode_o)
        wait_on(1, 1'h1, BW + 10, n);
        `CHK("idle power down time", 1'h1, n >= BW - 6)
        restrap(BOOT_SEL_NOR);
        `CHK("power down sticky", 1'h1, power_down_o)
        sys_reset();
        `CHK("power down cleared", 1'h0, power_down_o)
        $display("test serial idle done");
    endtask

    task automatic t_session();
        restrap(BOOT_SEL_SERIAL);
        uart_active_i <= 1'h1;
        tick(4);
        uart_active_i <= 1'h0;
        usb_active_i <= 1'h1;
        tick(4);
        usb_active_i <= 1'h0;
        repeat (5) begin
            tick(15);
            boot_service_i <= 1'h1;
            tick(3);
            boot_service_i <= 1'h0;
        end
        `CHK("serviced session alive", 1'h0, power_down_o)
        wait_on(1, 1'h1, BW + 10, n);
        `CHK("stalled session time", 1'h1, n >= BW - 6)
        boot_select_i <= BOOT_SEL_NOR;
        sys_reset();
        $display("test serial session done");
    endtask

    initial begin
        sys_reset();
        `CHK("default boot mode", MSRB_BOOT_NOR, boot_mode_o)
        t_manual();
        t_rails();
        t_pfail();
        t_boot_watchdog();
        t_modes();
        t_idle();
        t_session();
        close_out();
    end
endmodule
